// >>> verilog/lfs_defines.vh
// register map, field positions and reset values of the latched fault status bank
`ifndef LFS_DEFINES_VH
`define LFS_DEFINES_VH

`define LFS_ADDR_W 8
`define LFS_DATA_W 8

`define LFS_OFS_CH2_INPUT_FAULT_LATCH 8'h37
`define LFS_OFS_ADC_OVERLOAD_MASK 8'h38
`define LFS_OFS_REGULATOR_SHORT_LATCH 8'h39
`define LFS_OFS_OVERVOLTAGE_EVENT_LATCH 8'h3a

`define LFS_RST_CH2_INPUT_FAULT_LATCH 8'h00
`define LFS_RST_ADC_OVERLOAD_MASK 8'h00
`define LFS_RST_REGULATOR_SHORT_LATCH 8'h00
`define LFS_RST_OVERVOLTAGE_EVENT_LATCH 8'h00
`define LFS_UNMAPPED_READ 8'h00

// channel 2 input fault latch fields
`define LFS_CH2_OPEN_BIT 7
`define LFS_CH2_SHORTED_BIT 6
`define LFS_CH2_POS_GND_BIT 5
`define LFS_CH2_NEG_GND_BIT 4
`define LFS_CH2_POS_BIAS_BIT 3
`define LFS_CH2_NEG_BIAS_BIT 2
`define LFS_CH2_POS_BAT_BIT 1
`define LFS_CH2_NEG_BAT_BIT 0

// overload mask fields
`define LFS_CH1_OVERLOAD_MASK_BIT 3
`define LFS_CH2_OVERLOAD_MASK_BIT 2

// regulator short latch fields
`define LFS_REGULATOR_SHORT_MASK_BIT 1
`define LFS_REGULATOR_SHORT_FLAG_BIT 0

// over-voltage and event latch fields
`define LFS_OV_POS_ONE_BIT 7
`define LFS_OV_NEG_ONE_BIT 6
`define LFS_OV_POS_TWO_BIT 5
`define LFS_OV_NEG_TWO_BIT 4
`define LFS_HEADSET_INSERT_BIT 3
`define LFS_HEADSET_REMOVE_BIT 2
`define LFS_HEADSET_HOOK_BIT 1
`define LFS_CAPACITY_OVERLOAD_BIT 0

`endif

// >>> verilog/lfs_fault_status.v
// latched fault and event status bank with overload and regulator masks
//
// Notes on behaviour
// - the channel 2 input fault register latches each fault and holds it until the register is read.
// - bit 7 of the channel 2 fault register flags an open input on channel 2.
// - bit 6 of the channel 2 fault register flags the two channel 2 inputs shorted together.
// - bits 5 and 4 flag the positive and negative channel 2 inputs shorted to ground.
// - bits 3 and 2 flag the positive and negative channel 2 inputs shorted to mic bias.
// - bits 1 and 0 flag the positive and negative channel 2 inputs shorted to battery sense.
// - mask bit 3 of the overload mask register, when one, suppresses channel 1 overload reporting.
// - mask bit 2 of the overload mask register, when one, suppresses channel 2 overload reporting.
// - regulator register bit 0 latches a regulator short and writable bit 1 masks it.
// - event register bits 7 to 4 latch over-voltage on inputs one plus, one minus, two plus, two minus.
// - event register bit 3 latches a headset insertion.
// - event register bit 2 latches a headset removal.
// - event register bit 1 latches a headset hook button press.
// - event register bit 0 latches a processing capacity overload.
`timescale 1ns/1ps
`default_nettype none
`include "lfs_defines.vh"

module lfs_fault_status (
   input wire clk_i,
   input wire rst_i,
   input wire ce_i,
   // control port register access
   input wire [`LFS_ADDR_W-1:0] reg_addr_i,
   input wire reg_wr_i,
   input wire [`LFS_DATA_W-1:0] reg_wdata_i,
   input wire reg_rd_i,
   output reg [`LFS_DATA_W-1:0] reg_rdata_o,
   output reg reg_rvalid_o,
   // live fault conditions from the channel 2 input diagnostics
   input wire ch2_open_i,
   input wire ch2_shorted_i,
   input wire positive_input_two_gnd_i,
   input wire negative_input_two_gnd_i,
   input wire positive_input_two_bias_i,
   input wire negative_input_two_bias_i,
   input wire positive_input_two_bat_i,
   input wire negative_input_two_bat_i,
   // regulator and over-voltage conditions
   input wire analog_regulator_output_short_i,
   input wire positive_input_one_ov_i,
   input wire negative_input_one_ov_i,
   input wire positive_input_two_ov_i,
   input wire negative_input_two_ov_i,
   // headset and processing events
   input wire headset_insert_i,
   input wire headset_remove_i,
   input wire headset_hook_i,
   input wire processing_capacity_overload_i,
   // raw adc overload detections
   input wire ch1_adc_overload_i,
   input wire ch2_adc_overload_i,
   // masked fault reports
   output reg ch1_overload_report_o,
   output reg ch2_overload_report_o,
   output reg regulator_short_report_o
);

   // latched flags and their next values
   reg [7:0] ch2_fault_q;
   reg [7:0] ch2_fault_d;
   reg [7:0] ch2_fault_keep;
   reg [7:0] event_q;
   reg [7:0] event_d;
   reg [7:0] event_keep;
   reg reg_short_q;
   reg reg_short_d;
   reg reg_short_keep;
   // writable mask bits
   reg ch1_ovl_mask_q;
   reg ch1_ovl_mask_d;
   reg ch2_ovl_mask_q;
   reg ch2_ovl_mask_d;
   reg reg_short_mask_q;
   reg reg_short_mask_d;
   // live conditions gathered into register layout
   reg [7:0] ch2_fault_live;
   reg [7:0] event_live;
   // register images, read port and report next values
   reg [7:0] ovl_image;
   reg [7:0] reg_image;
   reg [7:0] rdata_d;
   reg rvalid_d;
   reg ch1_report_d;
   reg ch2_report_d;
   reg reg_short_report_d;
   // decoded strobes
   reg rd_ch2;
   reg rd_ovl;
   reg rd_reg;
   reg rd_evt;
   reg wr_ovl;
   reg wr_reg;

   // address decode, a read strobe per mapped register, write strobes for the overload mask and regulator registers only
   always @* begin
      rd_ch2 = 1'b0;
      rd_ovl = 1'b0;
      rd_reg = 1'b0;
      rd_evt = 1'b0;
      wr_ovl = 1'b0;
      wr_reg = 1'b0;
      if (reg_addr_i == `LFS_OFS_CH2_INPUT_FAULT_LATCH) begin
         rd_ch2 = reg_rd_i;
      end else if (reg_addr_i == `LFS_OFS_ADC_OVERLOAD_MASK) begin
         rd_ovl = reg_rd_i;
         wr_ovl = reg_wr_i;
      end else if (reg_addr_i == `LFS_OFS_REGULATOR_SHORT_LATCH) begin
         rd_reg = reg_rd_i;
         wr_reg = reg_wr_i;
      end else if (reg_addr_i == `LFS_OFS_OVERVOLTAGE_EVENT_LATCH) begin
         rd_evt = reg_rd_i;
      end
   end

   always @* begin
      ch2_fault_live = 8'h00;
      ch2_fault_live[`LFS_CH2_OPEN_BIT] = ch2_open_i;
      ch2_fault_live[`LFS_CH2_SHORTED_BIT] = ch2_shorted_i;
      ch2_fault_live[`LFS_CH2_POS_GND_BIT] = positive_input_two_gnd_i;
      ch2_fault_live[`LFS_CH2_NEG_GND_BIT] = negative_input_two_gnd_i;
      ch2_fault_live[`LFS_CH2_POS_BIAS_BIT] = positive_input_two_bias_i;
      ch2_fault_live[`LFS_CH2_NEG_BIAS_BIT] = negative_input_two_bias_i;
      ch2_fault_live[`LFS_CH2_POS_BAT_BIT] = positive_input_two_bat_i;
      ch2_fault_live[`LFS_CH2_NEG_BAT_BIT] = negative_input_two_bat_i;
   end

   always @* begin
      event_live = 8'h00;
      event_live[`LFS_OV_POS_ONE_BIT] = positive_input_one_ov_i;
      event_live[`LFS_OV_NEG_ONE_BIT] = negative_input_one_ov_i;
      event_live[`LFS_OV_POS_TWO_BIT] = positive_input_two_ov_i;
      event_live[`LFS_OV_NEG_TWO_BIT] = negative_input_two_ov_i;
      event_live[`LFS_HEADSET_INSERT_BIT] = headset_insert_i;
      event_live[`LFS_HEADSET_REMOVE_BIT] = headset_remove_i;
      event_live[`LFS_HEADSET_HOOK_BIT] = headset_hook_i;
      event_live[`LFS_CAPACITY_OVERLOAD_BIT] = processing_capacity_overload_i;
   end

   // clear on read
   // a condition present in the read cycle keeps its bit, so set wins over clear-on-read
   always @* begin
      if (rd_ch2) begin
         ch2_fault_keep = 8'h00;
      end else begin
         ch2_fault_keep = ch2_fault_q;
      end
      ch2_fault_d = ch2_fault_live | ch2_fault_keep;
   end

   always @* begin
      if (rd_evt) begin
         event_keep = 8'h00;
      end else begin
         event_keep = event_q;
      end
      event_d = event_live | event_keep;
   end

   always @* begin
      if (rd_reg) begin
         reg_short_keep = 1'b0;
      end else begin
         reg_short_keep = reg_short_q;
      end
      reg_short_d = analog_regulator_output_short_i | reg_short_keep;
   end

   // reserved bits are not stored, so stray ones written there read back zero
   always @* begin
      ch1_ovl_mask_d = ch1_ovl_mask_q;
      ch2_ovl_mask_d = ch2_ovl_mask_q;
      reg_short_mask_d = reg_short_mask_q;
      if (wr_ovl) begin
         ch1_ovl_mask_d = reg_wdata_i[`LFS_CH1_OVERLOAD_MASK_BIT];
         ch2_ovl_mask_d = reg_wdata_i[`LFS_CH2_OVERLOAD_MASK_BIT];
      end
      if (wr_reg) begin
         reg_short_mask_d = reg_wdata_i[`LFS_REGULATOR_SHORT_MASK_BIT];
      end
   end

   // reports use the mask held this cycle, so a new mask acts one cycle after its write
   always @* begin
      ch1_report_d = ch1_adc_overload_i & ~ch1_ovl_mask_q;
      ch2_report_d = ch2_adc_overload_i & ~ch2_ovl_mask_q;
      reg_short_report_d = reg_short_q & ~reg_short_mask_q;
   end

   // mask register image, reserved bits zero
   always @* begin
      ovl_image = `LFS_RST_ADC_OVERLOAD_MASK;
      ovl_image[`LFS_CH1_OVERLOAD_MASK_BIT] = ch1_ovl_mask_q;
      ovl_image[`LFS_CH2_OVERLOAD_MASK_BIT] = ch2_ovl_mask_q;
   end

   // regulator register image, reserved bits zero
   always @* begin
      reg_image = `LFS_RST_REGULATOR_SHORT_LATCH;
      reg_image[`LFS_REGULATOR_SHORT_MASK_BIT] = reg_short_mask_q;
      reg_image[`LFS_REGULATOR_SHORT_FLAG_BIT] = reg_short_q;
   end

   // read data shows the value held before the clear takes effect
   always @* begin
      rdata_d = `LFS_UNMAPPED_READ;
      if (rd_ch2) begin
         rdata_d = ch2_fault_q;
      end else if (rd_ovl) begin
         rdata_d = ovl_image;
      end else if (rd_reg) begin
         rdata_d = reg_image;
      end else if (rd_evt) begin
         rdata_d = event_q;
      end
   end

   // a read answers exactly one enabled edge later, mapped or not
   always @* begin
      rvalid_d = reg_rd_i;
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         ch2_fault_q <= `LFS_RST_CH2_INPUT_FAULT_LATCH;
      end else if (ce_i) begin
         ch2_fault_q <= ch2_fault_d;
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         event_q <= `LFS_RST_OVERVOLTAGE_EVENT_LATCH;
      end else if (ce_i) begin
         event_q <= event_d;
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         reg_short_q <= 1'b0;
      end else if (ce_i) begin
         reg_short_q <= reg_short_d;
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         ch1_ovl_mask_q <= 1'b0;
      end else if (ce_i) begin
         ch1_ovl_mask_q <= ch1_ovl_mask_d;
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         ch2_ovl_mask_q <= 1'b0;
      end else if (ce_i) begin
         ch2_ovl_mask_q <= ch2_ovl_mask_d;
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         reg_short_mask_q <= 1'b0;
      end else if (ce_i) begin
         reg_short_mask_q <= reg_short_mask_d;
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         reg_rdata_o <= 8'h00;
      end else if (ce_i) begin
         reg_rdata_o <= rdata_d;
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         reg_rvalid_o <= 1'b0;
      end else if (ce_i) begin
         reg_rvalid_o <= rvalid_d;
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         ch1_overload_report_o <= 1'b0;
      end else if (ce_i) begin
         ch1_overload_report_o <= ch1_report_d;
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         ch2_overload_report_o <= 1'b0;
      end else if (ce_i) begin
         ch2_overload_report_o <= ch2_report_d;
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         regulator_short_report_o <= 1'b0;
      end else if (ce_i) begin
         regulator_short_report_o <= reg_short_report_d;
      end
   end

endmodule // lfs_fault_status
`default_nettype wire

// >>> sim/lfs_host.sv
// host model driving the register port of the fault status bank
`timescale 1ns/1ps
`default_nettype none
module lfs_host (
   input wire logic clk_i,
   input wire logic [7:0] reg_rdata_i,
   input wire logic reg_rvalid_i,
   output logic [7:0] reg_addr_o,
   output logic reg_wr_o,
   output logic [7:0] reg_wdata_o,
   output logic reg_rd_o
);
   initial begin
      reg_addr_o = 8'h00;
      reg_wr_o = 1'b0;
      reg_wdata_o = 8'h00;
      reg_rd_o = 1'b0;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_i);
      reg_addr_o = a;
      reg_wdata_o = d;
      reg_wr_o = 1'b1;
      @(negedge clk_i);
      reg_wr_o = 1'b0;
      // released data shows the inverse so a stale value is never trusted
      reg_wdata_o = ~d;
   endtask
   // answer is fixed at the edge that takes the read and sampled half a cycle later
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
      @(negedge clk_i);
      reg_addr_o = a;
      reg_rd_o = 1'b1;
      @(negedge clk_i);
      reg_rd_o = 1'b0;
      ok = reg_rvalid_i;
      d = reg_rdata_i;
   endtask
endmodule // lfs_host
`default_nettype wire

// >>> sim/lfs_fault_status_asserts.sv
// concurrent checks on the ports of the fault status bank
`timescale 1ns/1ps
`default_nettype none
`include "lfs_defines.vh"
module lfs_fault_status_chk (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic ch1_adc_overload_i,
   input wire logic ch2_adc_overload_i,
   input wire logic ch1_overload_report_o,
   input wire logic ch2_overload_report_o,
   input wire logic analog_regulator_output_short_i,
   input wire logic headset_hook_i,
   input wire logic ch2_open_i,
   input wire logic processing_capacity_overload_i,
   input wire logic positive_input_one_ov_i
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire rd_ch2 = reg_rd_i && reg_addr_i == `LFS_OFS_CH2_INPUT_FAULT_LATCH;
   wire rd_reg = reg_rd_i && reg_addr_i == `LFS_OFS_REGULATOR_SHORT_LATCH;
   wire rd_evt = reg_rd_i && reg_addr_i == `LFS_OFS_OVERVOLTAGE_EVENT_LATCH;
   AST_OPEN: assert property (ch2_open_i ##1 !rd_ch2 ##1 rd_ch2 |=> reg_rdata_o[7])
      else $error("open input flag missing");
   AST_CH1_MASK: assert property (ch1_overload_report_o |-> $past(ch1_adc_overload_i))
      else $error("ch1 report without overload");
   AST_CH2_MASK: assert property (ch2_overload_report_o |-> $past(ch2_adc_overload_i))
      else $error("ch2 report without overload");
   AST_REG: assert property (analog_regulator_output_short_i ##1 rd_reg |=> reg_rdata_o[0])
      else $error("regulator flag missing");
   AST_OV: assert property (positive_input_one_ov_i ##1 !rd_evt [*5] ##1 rd_evt
      |=> reg_rdata_o[7])
      else $error("over-voltage flag missing");
   AST_HOOK: assert property (headset_hook_i ##1 !rd_evt [*5] ##1 rd_evt
      |=> reg_rdata_o[1])
      else $error("hook flag missing");
   AST_CAP: assert property (processing_capacity_overload_i ##1 !rd_evt [*5] ##1 rd_evt
      |=> reg_rdata_o[0])
      else $error("capacity flag missing");
   AST_CLEAR: assert property ((rd_evt && !headset_hook_i) ##1 !headset_hook_i ##1 rd_evt
      |=> !reg_rdata_o[1])
      else $error("hook flag not cleared by read");
endmodule // lfs_fault_status_chk
bind lfs_fault_status lfs_fault_status_chk chk (.*);
`default_nettype wire

// >>> sim/latched_fault_status_bank_bench.sv
// self-checking bench for the latched fault status bank
`timescale 1ns/1ps
`default_nettype none
`include "lfs_defines.vh"
module latched_fault_status_bank_bench;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] f37 = 8'h00;
   logic [7:0] f3a = 8'h00;
   logic [1:0] ovl = 2'b00;
   logic analog_regulator_output = 1'b0;
   wire [7:0] addr, wdata, rdata;
   wire wr, rd, rvalid, rep1, rep2, rep_reg;
   int mismatches = 0;
   int comparisons = 0;
   always #2 clk_i = ~clk_i;
   lfs_host host (.clk_i(clk_i), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid),
      .reg_addr_o(addr), .reg_wr_o(wr), .reg_wdata_o(wdata), .reg_rd_o(rd));
   lfs_fault_status dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .reg_addr_i(addr),
      .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata),
      .reg_rvalid_o(rvalid), .ch2_open_i(f37[7]), .ch2_shorted_i(f37[6]),
      .positive_input_two_gnd_i(f37[5]), .negative_input_two_gnd_i(f37[4]),
      .positive_input_two_bias_i(f37[3]), .negative_input_two_bias_i(f37[2]),
      .positive_input_two_bat_i(f37[1]), .negative_input_two_bat_i(f37[0]),
      .analog_regulator_output_short_i(analog_regulator_output), .positive_input_one_ov_i(f3a[7]),
      .negative_input_one_ov_i(f3a[6]), .positive_input_two_ov_i(f3a[5]),
      .negative_input_two_ov_i(f3a[4]), .headset_insert_i(f3a[3]),
      .headset_remove_i(f3a[2]), .headset_hook_i(f3a[1]),
      .processing_capacity_overload_i(f3a[0]), .ch1_adc_overload_i(ovl[1]),
      .ch2_adc_overload_i(ovl[0]), .ch1_overload_report_o(rep1),
      .ch2_overload_report_o(rep2), .regulator_short_report_o(rep_reg));
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      logic ok;
      host.rd(a, d, ok);
      check("rvalid", {7'h00, ok}, 8'h01);
      check("rdata", d, exp);
   endtask
   task automatic t_reset_refused;
      for (int i = 0; i < 4; i++) rchk(8'h37 + 8'(i), 8'h00);
      host.wr(`LFS_OFS_CH2_INPUT_FAULT_LATCH, 8'hff);
      rchk(`LFS_OFS_CH2_INPUT_FAULT_LATCH, 8'h00);
      host.wr(`LFS_OFS_ADC_OVERLOAD_MASK, 8'hff);
      rchk(`LFS_OFS_ADC_OVERLOAD_MASK, 8'h0c);
      rchk(8'h50, `LFS_UNMAPPED_READ);
   endtask
   task automatic t_masks;
      for (int m = 0; m < 4; m++) begin
         host.wr(`LFS_OFS_ADC_OVERLOAD_MASK, {4'h0, 2'(m), 2'b00});
         @(negedge clk_i);
         ovl = 2'b11;
         repeat (2) @(negedge clk_i);
         check("rep1", {7'h00, rep1}, {7'h00, ~m[1]});
         check("rep2", {7'h00, rep2}, {7'h00, ~m[0]});
         ovl = 2'b00;
      end
   endtask
   // one-cycle pulse per flag: caught, read once, then cleared
   task automatic t_latch;
      for (int i = 0; i < 8; i++) begin
         @(negedge clk_i);
         f37 = 8'h01 << i;
         f3a = 8'h80 >> i;
         @(negedge clk_i);
         f37 = 8'h00;
         f3a = 8'h00;
         rchk(`LFS_OFS_CH2_INPUT_FAULT_LATCH, 8'h01 << i);
         rchk(`LFS_OFS_CH2_INPUT_FAULT_LATCH, 8'h00);
         rchk(`LFS_OFS_OVERVOLTAGE_EVENT_LATCH, 8'h80 >> i);
         rchk(`LFS_OFS_OVERVOLTAGE_EVENT_LATCH, 8'h00);
      end
   endtask
   task automatic t_regulator;
      @(negedge clk_i);
      analog_regulator_output = 1'b1;
      repeat (3) @(negedge clk_i);
      check("rep_reg", {7'h00, rep_reg}, 8'h01);
      rchk(`LFS_OFS_REGULATOR_SHORT_LATCH, 8'h01);
      analog_regulator_output = 1'b0;
      rchk(`LFS_OFS_REGULATOR_SHORT_LATCH, 8'h01);
      rchk(`LFS_OFS_REGULATOR_SHORT_LATCH, 8'h00);
      host.wr(`LFS_OFS_REGULATOR_SHORT_LATCH, 8'h02);
      analog_regulator_output = 1'b1;
      repeat (3) @(negedge clk_i);
      check("rep_reg", {7'h00, rep_reg}, 8'h00);
      rchk(`LFS_OFS_REGULATOR_SHORT_LATCH, 8'h03);
   endtask
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (20) @(negedge clk_i);
      rst_i = 1'b0;
      t_reset_refused();
      t_masks();
      t_latch();
      t_regulator();
      stop_test();
   end
endmodule // latched_fault_status_bank_bench
`default_nettype wire
